// [lcdc_decoder.sv]
// Purpose: command decoder, pointers and display flags of the controller
// Assumes: host port strobes are one cycle, synchronous to sys_clk_in
// Notes: ram and analog blocks sit outside, fed by ram_out and drv_out
`timescale 1ns/100ps
module lcdc_decoder import lcdc_pkg::*; #(
	parameter int RESET_CYCLES = RESET_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic host_cd_in,
	input wire logic [7:0] host_data_in,
	input wire logic [7:0] ram_rdata_in,
	input wire logic [1:0] strap_bias_in,
	input wire logic [1:0] strap_mux_in,
	output logic [7:0] host_rdata_out,
	output lcdc_ram_s ram_out,
	output lcdc_drv_s drv_out,
	output logic [5:0] fine_trim_out,
	output logic [2:0] pump_config_out,
	output logic [1:0] bias_select_out,
	output logic [6:0] mux_rows_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	lcdc_pwr_e pwr_r;
	logic [7:0] column_pointer_r;
	logic [7:0] column_return_r;
	logic [3:0] bank_index_r;
	logic [3:0] addressing_ctl_r;
	logic [3:0] map_control_r;
	logic [2:0] display_flags_r;
	logic [5:0] fine_trim_r;
	logic [2:0] pump_config_r;
	logic [1:0] bias_select_r;
	logic [1:0] param_wait_r;
	logic reset_pending_r;
	logic strap_taken_r;
	logic [22:0] rst_cnt_r;
	logic [15:0] pwr_cnt_r;

	logic cmd_wr;
	logic param_wr;
	logic data_wr;
	logic data_rd;
	logic soft_rst;
	logic advance;
	logic wrap_on;
	logic [7:0] data_flip;

	// ----------------------------------------------------------------
	// host decode
	// ----------------------------------------------------------------
	// reset_pending blocks every host access except status reads
	assign cmd_wr = host_wr_in && !host_cd_in && !reset_pending_r && param_wait_r == 2'h0;
	assign param_wr = host_wr_in && !host_cd_in && !reset_pending_r && param_wait_r != 2'h0;
	assign data_wr = host_wr_in && host_cd_in && !reset_pending_r;
	assign data_rd = host_rd_in && host_cd_in && !reset_pending_r;
	// exact match only, so the no-operation code next to it changes nothing
	assign soft_rst = cmd_wr && host_data_in == CMD_SYSRST;

	// cursor mode: reads never advance, wrap suspended
	assign advance = data_wr || (data_rd && !addressing_ctl_r[AC_CURSOR]);
	assign wrap_on = addressing_ctl_r[AC_WRAP] && !addressing_ctl_r[AC_CURSOR];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flip
			assign data_flip[gi] = map_control_r[MC_HBF] ? host_data_in[7 - gi] : host_data_in[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// two-byte commands
	// ----------------------------------------------------------------
	// 1 = trim parameter, 2 = swallowed test/config parameter
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			param_wait_r <= 2'h0;
		end else if (soft_rst) begin
			param_wait_r <= 2'h0;
		end else if (param_wr) begin
			param_wait_r <= 2'h0;
		end else if (cmd_wr && host_data_in == CMD_TRIM) begin
			param_wait_r <= 2'h1;
		end else if (cmd_wr && (host_data_in[7:2] == CMD_TEST[6:1]
			|| host_data_in[7:1] == CMD_PROD_CFG[7:1])) begin
			// test opener carries two free low bits, so all four codes swallow
			param_wait_r <= 2'h2;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fine_trim_r <= TRIM_RST;
		end else if (soft_rst) begin
			fine_trim_r <= TRIM_RST;
		end else if (param_wr && param_wait_r == 2'h1) begin
			fine_trim_r <= host_data_in[5:0];
		end
	end

	// ----------------------------------------------------------------
	// system reset
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reset_pending_r <= 1'b0;
			rst_cnt_r <= '0;
		end else if (soft_rst) begin
			reset_pending_r <= 1'b1;
			rst_cnt_r <= 23'((RESET_CYCLES > 1) ? RESET_CYCLES - 1 : 1);
		end else if (reset_pending_r) begin
			if (rst_cnt_r == 23'h0) begin
				reset_pending_r <= 1'b0;
			end else begin
				rst_cnt_r <= rst_cnt_r - 23'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addressing_ctl_r <= 4'h0;
			column_return_r <= 8'h00;
		end else if (soft_rst) begin
			addressing_ctl_r <= 4'h0;
			column_return_r <= 8'h00;
		end else if (cmd_wr && host_data_in[7:3] == CMD_ADDR) begin
			// reserved bit forced to zero
			addressing_ctl_r[2:0] <= {host_data_in[2], 1'b0, host_data_in[0]};
		end else if (cmd_wr && host_data_in == CMD_CUR_ON) begin
			addressing_ctl_r[AC_CURSOR] <= 1'b1;
			column_return_r <= column_pointer_r;
		end else if (cmd_wr && host_data_in == CMD_CUR_OFF) begin
			addressing_ctl_r[AC_CURSOR] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			map_control_r <= 4'h0;
		end else if (soft_rst) begin
			map_control_r <= 4'h0;
		end else if (cmd_wr && host_data_in[7:4] == CMD_MAP) begin
			map_control_r <= {host_data_in[3:2], 1'b0, host_data_in[0]};
		end else if (cmd_wr && host_data_in[7:1] == CMD_ROWFLIP) begin
			map_control_r[MC_ROWFLIP] <= host_data_in[0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			display_flags_r <= 3'h0;
		end else if (soft_rst) begin
			display_flags_r <= 3'h0;
		end else if (cmd_wr && host_data_in[7:1] == CMD_ALLON) begin
			display_flags_r[DF_ALLON] <= host_data_in[0];
		end else if (cmd_wr && host_data_in[7:1] == CMD_INVERT) begin
			display_flags_r[DF_INVERT] <= host_data_in[0];
		end else if (cmd_wr && host_data_in[7:1] == CMD_DRV) begin
			display_flags_r[DF_DRV] <= host_data_in[0];
		end
	end

	// pump value is taken as written; writes are ignored while reset is pending
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pump_config_r <= PUMP_RST;
		end else if (soft_rst) begin
			pump_config_r <= PUMP_RST;
		end else if (cmd_wr && host_data_in[7:3] == CMD_PUMP) begin
			pump_config_r <= host_data_in[2:0];
		end
	end

	// strap caught on the first clock after release and after soft reset
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bias_select_r <= 2'h0;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r || soft_rst) begin
			bias_select_r <= strap_bias_in;
			strap_taken_r <= 1'b1;
		end else if (cmd_wr && host_data_in[7:2] == CMD_BIAS) begin
			bias_select_r <= host_data_in[1:0];
		end
	end

	// ----------------------------------------------------------------
	// pointers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			column_pointer_r <= 8'h00;
		end else if (soft_rst) begin
			column_pointer_r <= 8'h00;
		end else if (cmd_wr && host_data_in[7:4] == CMD_COL_LO) begin
			column_pointer_r[3:0] <= host_data_in[3:0];
		end else if (cmd_wr && host_data_in[7:4] == CMD_COL_HI) begin
			column_pointer_r[7:4] <= host_data_in[3:0];
		end else if (cmd_wr && host_data_in == CMD_CUR_OFF) begin
			column_pointer_r <= column_return_r;
		end else if (advance) begin
			if (column_pointer_r < COL_LAST) begin
				column_pointer_r <= column_pointer_r + 8'h01;
			end else if (wrap_on) begin
				column_pointer_r <= 8'h00;
			end
			// otherwise hold at the end of the page
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bank_index_r <= 4'h0;
		end else if (soft_rst) begin
			bank_index_r <= 4'h0;
		end else if (cmd_wr && host_data_in[7:4] == CMD_BANK) begin
			bank_index_r <= host_data_in[3:0];
		end else if (advance && column_pointer_r >= COL_LAST && wrap_on) begin
			// bank wraps across its 0..8 range
			if (addressing_ctl_r[AC_STEP_DN]) begin
				bank_index_r <= (bank_index_r == 4'h0) ? BANK_LAST : bank_index_r - 4'h1;
			end else begin
				bank_index_r <= (bank_index_r >= BANK_LAST) ? 4'h0 : bank_index_r + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// ram request and host read data
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ram_out <= '0;
		end else begin
			ram_out.bank <= bank_index_r;
			ram_out.column <= map_control_r[MC_COLFLIP] ? COL_LAST - column_pointer_r
				: column_pointer_r;
			ram_out.data <= data_flip;
			ram_out.wr <= data_wr;
			ram_out.rd <= data_rd;
		end
	end

	// status on control reads, ram data on data reads
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			host_rdata_out <= 8'h00;
		end else if (host_rd_in && !host_cd_in) begin
			host_rdata_out <= {reset_pending_r || pwr_r != PWR_ACTIVE && pwr_r != PWR_SLEEP,
				map_control_r[MC_COLFLIP], display_flags_r[DF_DRV], reset_pending_r,
				4'h0};
		end else if (data_rd) begin
			host_rdata_out <= ram_rdata_in;
		end else begin
			host_rdata_out <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// driver power sequence
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pwr_r <= PWR_SLEEP;
			pwr_cnt_r <= '0;
		end else if (!display_flags_r[DF_DRV] || reset_pending_r) begin
			pwr_r <= reset_pending_r ? PWR_RESET : PWR_SLEEP;
			pwr_cnt_r <= '0;
		end else begin
			unique case (pwr_r)
				PWR_SLEEP, PWR_RESET: begin
					pwr_r <= PWR_WAKE;
					pwr_cnt_r <= 16'(WAKE_CYC - 1);
				end
				PWR_WAKE: begin
					if (pwr_cnt_r == 16'h0) begin
						pwr_r <= PWR_SUPPLY;
						pwr_cnt_r <= 16'(POWER_CYC - 1);
					end else begin
						pwr_cnt_r <= pwr_cnt_r - 16'h1;
					end
				end
				PWR_SUPPLY: begin
					if (pwr_cnt_r == 16'h0) begin
						pwr_r <= PWR_ACTIVE;
					end else begin
						pwr_cnt_r <= pwr_cnt_r - 16'h1;
					end
				end
				PWR_ACTIVE: begin
					pwr_r <= PWR_ACTIVE;
				end
			endcase
		end
	end

	// flags only reach the segments while drivers are active
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			drv_out <= '0;
		end else begin
			drv_out.rows_en <= pwr_r == PWR_ACTIVE;
			drv_out.seg_en <= pwr_r == PWR_ACTIVE;
			drv_out.force_on <= pwr_r == PWR_ACTIVE && display_flags_r[DF_ALLON];
			drv_out.invert <= pwr_r == PWR_ACTIVE && display_flags_r[DF_INVERT];
			drv_out.row_flip <= map_control_r[MC_ROWFLIP];
			drv_out.sleep <= pwr_r == PWR_SLEEP || pwr_r == PWR_RESET;
			drv_out.supply_on <= pwr_r == PWR_SUPPLY || pwr_r == PWR_ACTIVE;
		end
	end

	// ----------------------------------------------------------------
	// analog settings
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fine_trim_out <= TRIM_RST;
			pump_config_out <= PUMP_RST;
			bias_select_out <= 2'h0;
			mux_rows_out <= MUX_25;
		end else begin
			fine_trim_out <= fine_trim_r;
			pump_config_out <= pump_config_r;
			bias_select_out <= bias_select_r;
			unique case (strap_mux_in)
				2'h0: mux_rows_out <= MUX_25;
				2'h1: mux_rows_out <= MUX_33;
				2'h2: mux_rows_out <= MUX_49;
				2'h3: mux_rows_out <= MUX_65;
			endcase
		end
	end
endmodule

// [lcdc_pkg.sv]
// Purpose: constants and types for the display controller command decoder
// Assumes: one 40 MHz clock, host bytes arrive as single-cycle strobes
// Notes: holds command codes, field positions, reset values and timing
// Notes on behaviour
// - 1011xxxx loads bank_index from low nibble
// - 10000001 then byte: bits 5:0 to fine_trim
// - 10001xyz loads bank_step_down, reserved, wrap bits
// - wrap at column end, step bank up/down
// - 1010000x sets row_flip, display only
// - 1010010x writes force_all_on
// - 1010011x writes invert_pixels
// - 1100xxxx loads map_control bits 3, 2 and 0, bit 1 cleared
// - column_flip uses 131 minus column_pointer
// - high_bit_first reverses stored data bits
// - 11100010 resets registers, takes about 5 ms
// - 11100011 is a no-operation
// - 111010xx loads bias_select, overriding strap
// - 11101111 sets cursor mode, saves column
// - cursor mode: advance on writes, no wrap
// - 11101110 clears cursor mode, restores column
// - mux_select comes only from strap pins
// - drivers off: rows floating, segments low, sleep
// - drivers on: wake, power, then drivers
// - drivers_on overrides force_all_on and invert_pixels
// - status byte: busy, column_flip, drivers_on, reset
// - mux strap 00=25,01=33,10=49,11=65 rows
// - no wrap: column stops at end, bank holds
package lcdc_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int RESET_TIME_US = 5000;
	localparam int RESET_CYC = (CLK_HZ / 1000000) * RESET_TIME_US;
	localparam int WAKE_TIME_US = 10;
	localparam int WAKE_CYC = (CLK_HZ / 1000000) * WAKE_TIME_US;
	localparam int POWER_TIME_US = 20;
	localparam int POWER_CYC = (CLK_HZ / 1000000) * POWER_TIME_US;

	localparam logic [7:0] COL_LAST = 8'h83;
	localparam logic [3:0] BANK_LAST = 4'h8;

	localparam logic [7:0] CMD_TRIM = 8'h81;
	localparam logic [7:0] CMD_SYSRST = 8'hE2;
	localparam logic [7:0] CMD_NOP = 8'hE3;
	localparam logic [7:0] CMD_CUR_ON = 8'hEF;
	localparam logic [7:0] CMD_CUR_OFF = 8'hEE;
	localparam logic [7:0] CMD_PROD_CFG = 8'h30;
	localparam logic [6:0] CMD_ROWFLIP = 7'h50;
	localparam logic [6:0] CMD_ALLON = 7'h52;
	localparam logic [6:0] CMD_INVERT = 7'h53;
	localparam logic [6:0] CMD_DRV = 7'h57;
	localparam logic [6:0] CMD_TEST = 7'h72;
	localparam logic [3:0] CMD_BANK = 4'hB;
	localparam logic [3:0] CMD_MAP = 4'hC;
	localparam logic [3:0] CMD_COL_LO = 4'h0;
	localparam logic [3:0] CMD_COL_HI = 4'h1;
	localparam logic [4:0] CMD_ADDR = 5'h11;
	localparam logic [4:0] CMD_PUMP = 5'h05;
	localparam logic [5:0] CMD_BIAS = 6'h3A;

	localparam int AC_WRAP = 0;
	localparam int AC_STEP_DN = 2;
	localparam int AC_CURSOR = 3;
	localparam int MC_HBF = 0;
	localparam int MC_COLFLIP = 2;
	localparam int MC_ROWFLIP = 3;
	localparam int DF_INVERT = 0;
	localparam int DF_ALLON = 1;
	localparam int DF_DRV = 2;

	localparam logic [5:0] TRIM_RST = 6'h10;
	localparam logic [2:0] PUMP_RST = 3'h7;
	localparam logic [6:0] MUX_25 = 7'h19;
	localparam logic [6:0] MUX_33 = 7'h21;
	localparam logic [6:0] MUX_49 = 7'h31;
	localparam logic [6:0] MUX_65 = 7'h41;

	typedef enum logic [4:0] {
		PWR_SLEEP = 5'b00001,
		PWR_WAKE = 5'b00010,
		PWR_SUPPLY = 5'b00100,
		PWR_ACTIVE = 5'b01000,
		PWR_RESET = 5'b10000
	} lcdc_pwr_e;

	typedef struct packed {
		logic [3:0] bank;
		logic [7:0] column;
		logic [7:0] data;
		logic wr;
		logic rd;
	} lcdc_ram_s;

	typedef struct packed {
		logic rows_en;
		logic seg_en;
		logic force_on;
		logic invert;
		logic row_flip;
		logic sleep;
		logic supply_on;
	} lcdc_drv_s;
endpackage

// [lcdc_decoder_props.sv]
// Purpose: port-level checks for the command decoder
// Assumes: one clock, async active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/100ps
module lcdc_decoder_props import lcdc_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic host_rd_in,
	input wire logic host_wr_in,
	input wire logic host_cd_in,
	input wire logic [1:0] strap_mux_in,
	input wire logic [7:0] host_rdata_out,
	input wire lcdc_ram_s ram_out,
	input wire lcdc_drv_s drv_out,
	input wire logic [6:0] mux_rows_out
);
	// ----
	// helpers
	// ----
	localparam logic [6:0] MUX_TAB [4] = '{MUX_25, MUX_33, MUX_49, MUX_65};
	logic [1:0] up_cnt_r;
	// strap path needs three edges after release before it is trusted
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			up_cnt_r <= 2'h0;
		end else if (up_cnt_r != 2'h3) begin
			up_cnt_r <= up_cnt_r + 2'h1;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_rdata_idle: assert property (!$past(host_rd_in) |-> host_rdata_out == 8'h00)
		else $error("read data outside answer cycle");
	a_status_low: assert property ($past(host_rd_in) && !$past(host_cd_in)
		|-> host_rdata_out[3:0] == 4'h0) else $error("status low bits set");
	a_wr_cause: assert property (ram_out.wr |-> $past(host_wr_in) && $past(host_cd_in))
		else $error("ram write without data write");
	a_rd_cause: assert property (ram_out.rd |-> $past(host_rd_in) && $past(host_cd_in))
		else $error("ram read without data read");
	a_ptr_range: assert property (ram_out.wr || ram_out.rd
		|-> ram_out.bank <= BANK_LAST && ram_out.column <= COL_LAST)
		else $error("pointer out of range");
	a_mux_strap: assert property (up_cnt_r == 2'h3
		|-> mux_rows_out == MUX_TAB[$past(strap_mux_in)]) else $error("mux rows off strap");
	a_sleep_idle: assert property (drv_out.sleep |-> !drv_out.rows_en && !drv_out.seg_en)
		else $error("drivers active in sleep");
	a_drv_pair: assert property (drv_out.rows_en == drv_out.seg_en)
		else $error("row and segment enables differ");
	a_wake_order: assert property ($rose(drv_out.rows_en)
		|-> drv_out.supply_on && !drv_out.sleep && $past(drv_out.supply_on, 8))
		else $error("drivers on before supply");
	a_supply_after: assert property ($rose(drv_out.supply_on)
		|-> !drv_out.sleep && !drv_out.rows_en) else $error("supply order wrong");
	a_flag_gate: assert property (!drv_out.seg_en |-> !drv_out.force_on && !drv_out.invert)
		else $error("flags active with drivers off");
endmodule
bind lcdc_decoder lcdc_decoder_props u_lcdc_decoder_props(.sys_clk_in(sys_clk_in),
	.rst_b_in(rst_b_in), .host_rd_in(host_rd_in), .host_wr_in(host_wr_in),
	.host_cd_in(host_cd_in), .strap_mux_in(strap_mux_in), .host_rdata_out(host_rdata_out),
	.ram_out(ram_out), .drv_out(drv_out), .mux_rows_out(mux_rows_out));

// [lcdc_ram_model.sv]
// Purpose: display ram behind the decoder
// Assumes: ram_in strobes are one-cycle pulses
// Notes: read data follow the last accessed address, like a pipeline
`timescale 1ns/100ps
module lcdc_ram_model import lcdc_pkg::*; (
	input wire logic sys_clk_in,
	input wire lcdc_ram_s ram_in,
	output logic [7:0] rdata_out
);
	// ----
	// storage
	// ----
	logic [7:0] mem_r [9][132];
	logic [3:0] bank_r = 4'h0;
	logic [7:0] col_r = 8'h00;
	always_ff @(posedge sys_clk_in) begin
		if (ram_in.wr) begin
			mem_r[ram_in.bank][ram_in.column] <= ram_in.data;
		end
		if (ram_in.wr || ram_in.rd) begin
			bank_r <= ram_in.bank;
			col_r <= ram_in.column;
		end
	end
	assign rdata_out = mem_r[bank_r][col_r];
endmodule

// [tb.sv]
// Purpose: self-checking bench for the command decoder
// Assumes: soft reset shortened to 20 cycles
// Notes: host port driven through write and read tasks
`timescale 1ns/100ps
module tb import lcdc_pkg::*;;
	logic sys_clk_in, rst_b_in, host_wr_in, host_rd_in, host_cd_in;
	logic [7:0] host_data_in, ram_rdata_in, host_rdata_out, rd_v;
	logic [1:0] strap_bias_in, strap_mux_in, bias_select_out;
	logic [5:0] fine_trim_out;
	logic [2:0] pump_config_out;
	logic [6:0] mux_rows_out;
	logic [6:0] mux_tab [4] = '{MUX_25, MUX_33, MUX_49, MUX_65};
	lcdc_ram_s ram_out;
	lcdc_drv_s drv_out;
	int miscompares = 0;
	int checked = 0;
	lcdc_decoder #(.RESET_CYCLES(20)) u_lcdc_decoder(.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
		.host_cd_in(host_cd_in), .host_data_in(host_data_in), .ram_rdata_in(ram_rdata_in),
		.strap_bias_in(strap_bias_in), .strap_mux_in(strap_mux_in),
		.host_rdata_out(host_rdata_out), .ram_out(ram_out), .drv_out(drv_out),
		.fine_trim_out(fine_trim_out), .pump_config_out(pump_config_out),
		.bias_select_out(bias_select_out), .mux_rows_out(mux_rows_out));
	lcdc_ram_model u_lcdc_ram_model(.sys_clk_in(sys_clk_in), .ram_in(ram_out),
		.rdata_out(ram_rdata_in));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic cd, input logic [7:0] d);
		@(posedge sys_clk_in);
		host_wr_in <= 1'b1;
		host_cd_in <= cd;
		host_data_in <= d;
		@(posedge sys_clk_in);
		host_wr_in <= 1'b0;
		#1;
	endtask
	task automatic cmd(input logic [7:0] d);
		wr(1'b0, d);
	endtask
	task automatic rd(input logic cd);
		@(posedge sys_clk_in);
		host_rd_in <= 1'b1;
		host_cd_in <= cd;
		@(posedge sys_clk_in);
		host_rd_in <= 1'b0;
		#1;
		rd_v = host_rdata_out;
	endtask
	task automatic col(input logic [7:0] c);
		cmd({4'h0, c[3:0]});
		cmd({4'h1, c[7:4]});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	// ram write, then expect the placement it got
	task automatic dwr(input logic [7:0] d, input logic [3:0] b, input logic [7:0] c);
		wr(1'b1, d);
		chk({ram_out.wr, ram_out.bank, ram_out.column}, {1'b1, b, c});
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	// power-up alone is about 1200 cycles; whole run well under 8000
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		miscompares++;
		end_of_test();
	end
	initial begin
		{rst_b_in, host_wr_in, host_rd_in, host_cd_in, host_data_in} = '0;
		strap_bias_in = 2'h1;
		strap_mux_in = 2'h2;
		repeat (8) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		wt(3);
		chk({fine_trim_out, pump_config_out, bias_select_out, mux_rows_out},
			{TRIM_RST, PUMP_RST, 2'h1, MUX_49});
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk_in);
			strap_mux_in <= i[1:0];
			wt(3);
			chk(mux_rows_out, mux_tab[i]);
		end
		cmd(8'h89);
		cmd(8'hB8);
		col(8'd131);
		dwr(8'h55, 4'h8, 8'd131);
		dwr(8'h55, 4'h0, 8'd0);
		cmd(8'h8F);
		cmd(8'hB0);
		col(8'd131);
		dwr(8'h55, 4'h0, 8'd131);
		dwr(8'h55, 4'h8, 8'd0);
		cmd(8'h88);
		cmd(8'hB3);
		col(8'd131);
		dwr(8'h55, 4'h3, 8'd131);
		dwr(8'h55, 4'h3, 8'd131);
		cmd(8'hC5);
		col(8'd10);
		wr(1'b1, 8'h01);
		chk({ram_out.column, ram_out.data}, {8'd121, 8'h80});
		rd(1'b0);
		chk(rd_v, 8'h40);
		cmd(8'hC8);
		wt(2);
		chk(drv_out.row_flip, 1'b1);
		cmd(8'hA0);
		wt(2);
		chk(drv_out.row_flip, 1'b0);
		col(8'd20);
		wr(1'b1, 8'h3C);
		col(8'd20);
		rd(1'b1);
		chk({rd_v, ram_out.rd, ram_out.column}, {8'h3C, 1'b1, 8'd20});
		cmd(8'h81);
		cmd(8'hEF);
		wt(2);
		chk(fine_trim_out, 6'h2F);
		rd(1'b1);
		chk(ram_out.column, 8'd21);
		rd(1'b1);
		chk(ram_out.column, 8'd22);
		col(8'd40);
		cmd(8'hEF);
		rd(1'b1);
		rd(1'b1);
		chk(ram_out.column, 8'd40);
		dwr(8'h11, 4'h3, 8'd40);
		dwr(8'h11, 4'h3, 8'd41);
		cmd(8'hEE);
		dwr(8'h11, 4'h3, 8'd40);
		cmd(8'hE3);
		dwr(8'h11, 4'h3, 8'd41);
		chk(fine_trim_out, 6'h2F);
		cmd(8'hE6);
		cmd(8'hEE);
		dwr(8'h11, 4'h3, 8'd42);
		cmd(8'hEA);
		wt(2);
		chk(bias_select_out, 2'h2);
		cmd(8'hA5);
		cmd(8'hA7);
		wt(2);
		chk({drv_out.force_on, drv_out.invert, drv_out.seg_en, drv_out.sleep}, 4'h1);
		cmd(8'hAF);
		rd(1'b0);
		chk(rd_v, 8'hA0);
		for (int n = 0; n < 2000 && drv_out.rows_en !== 1'b1; n++) @(posedge sys_clk_in);
		wt(1);
		chk({drv_out.force_on, drv_out.invert, drv_out.seg_en, drv_out.supply_on}, 4'hF);
		rd(1'b0);
		chk(rd_v, 8'h20);
		cmd(8'hA4);
		cmd(8'hA6);
		wt(2);
		chk({drv_out.force_on, drv_out.invert}, 2'h0);
		cmd(8'hAE);
		wt(3);
		chk({drv_out.rows_en, drv_out.seg_en, drv_out.sleep}, 3'h1);
		cmd(8'hE2);
		rd(1'b0);
		chk(rd_v, 8'h90);
		wr(1'b1, 8'h77);
		chk(ram_out.wr, 1'b0);
		wt(30);
		rd(1'b0);
		chk(rd_v, 8'h00);
		chk({fine_trim_out, pump_config_out, bias_select_out}, {TRIM_RST, PUMP_RST, 2'h1});
		cmd(8'h2A);
		wt(2);
		chk(pump_config_out, 3'h2);
		end_of_test();
	end
endmodule
